// ==== hdl/gpc_edge_sync.v ====
`timescale 1ns/1ps

module gpc_edge_sync
(
  // clock and reset
  input  wire clk_in,
  input  wire rst_in,
  // asynchronous level
  input  wire async_in,
  // filtered level and edges
  output reg  level_out,
  output reg  rise_out,
  output reg  fall_out
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // ************************************************************
  // three-stage synchroniser, change accepted when stages 2 and 3 agree
  // ************************************************************
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s1_q      <= 1'h0;
      s2_q      <= 1'h0;
      s3_q      <= 1'h0;
      level_out <= 1'h0;
      rise_out  <= 1'h0;
      fall_out  <= 1'h0;
    end
    else
    begin
      s1_q     <= async_in;
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      rise_out <= 1'h0;
      fall_out <= 1'h0;
      if (s2_q == s3_q)
      begin
        level_out <= s3_q;
        rise_out  <= s3_q & ~level_out;
        fall_out  <= ~s3_q & level_out;
      end
    end
  end

endmodule // gpc_edge_sync

// ==== hdl/gpc_io_cell.v ====
// How it works
// - input mode opens only pad-to-core; direct or captured on chosen capture edge
// - bypass input path is never registered by any option
// - dual-edge input on non-differential pads: rising and falling capture registers give two core streams
// - output mode opens only core-to-pad; direct or launched on chosen launch edge
// - option inverts output register value before the pad
// - dual-edge output on non-differential pads: rising and falling launch registers muxed into one stream
// - bidirectional: all paths on; capture clocks input, launch clocks output and enable
// - bidirectional: every register has its own rising or falling edge choice
// - bidirectional: input and output registering chosen independently
// - clock output mode drives core clock tree level onto the pad
// - during configuration ordinary pads hold a weak pull-up
// - during configuration differential pins are tri-stated with no pull
// - unused pads in user mode tri-state with pull-up, or pull-down if chosen on non-differential pads
// - pad data to core, core data and optionally registered drive enable to pad
// - bypass routes to clock, control or pll reference only when input unregistered
`timescale 1ns/1ps
`include "gpc_regs.vh"

module gpc_io_cell
(
  // clock and reset
  input  wire                   clk_in,
  input  wire                   rst_in,
  // register port
  input  wire [`GPC_ADDR_W-1:0] reg_addr_in,
  input  wire [31:0]            reg_wdata_in,
  input  wire                   reg_wr_in,
  input  wire                   reg_rd_in,
  output reg  [31:0]            reg_rdata_out,
  // core side
  input  wire                   capture_clock_in,
  input  wire                   launch_clock_in,
  input  wire                   clock_tree_in,
  input  wire [1:0]             core_out_in,
  input  wire                   core_oe_in,
  output reg  [1:0]             core_in_out,
  // bypass input routing
  output reg                    global_clock_net_out,
  output reg                    global_control_net_out,
  output reg                    pll_reference_input_out,
  // pad
  input  wire                   pad_in,
  output reg                    pad_out,
  output reg                    pad_oe_n_out,
  output reg                    pad_pull_up_out,
  output reg                    pad_pull_down_out
);

  // ************************************************************
  // phase states
  // ************************************************************
  localparam ST_CONFIG = 2'b01;
  localparam ST_USER   = 2'b10;

  reg [`GPC_CTRL_W-1:0]  ctrl_q;
  reg [`GPC_ROUTE_W-1:0] route_q;
  reg [1:0]              state_q;
  reg [1:0]              state_d;

  wire cap_lvl;
  wire cap_rise;
  wire cap_fall;
  wire lch_lvl;
  wire lch_rise;
  wire lch_fall;
  wire pad_lvl;
  wire tree_lvl;

  // ************************************************************
  // configuration fields
  // ************************************************************
  wire [1:0] mode      = ctrl_q[`GPC_CTRL_MODE_MSB:`GPC_CTRL_MODE_LSB];
  wire       in_reg    = ctrl_q[`GPC_CTRL_IN_REG];
  wire       in_fall   = ctrl_q[`GPC_CTRL_IN_FALL];
  wire       out_reg   = ctrl_q[`GPC_CTRL_OUT_REG];
  wire       out_fall  = ctrl_q[`GPC_CTRL_OUT_FALL];
  wire       out_inv   = ctrl_q[`GPC_CTRL_OUT_INV];
  wire       oe_reg    = ctrl_q[`GPC_CTRL_OE_REG];
  wire       oe_fall   = ctrl_q[`GPC_CTRL_OE_FALL];
  wire       diff_pin  = ctrl_q[`GPC_CTRL_DIFF_PIN];
  // differential pins have no dual-edge registers
  wire       dual_in   = ctrl_q[`GPC_CTRL_DUAL_IN] & ~diff_pin;
  wire       dual_out  = ctrl_q[`GPC_CTRL_DUAL_OUT] & ~diff_pin;
  wire       pull_down = ctrl_q[`GPC_CTRL_PULL_DOWN];
  wire       used      = ctrl_q[`GPC_CTRL_USED];
  wire       user_mode = state_q[1];

  wire in_path_on  = (mode == `GPC_MODE_INPUT) || (mode == `GPC_MODE_BIDIR);
  wire out_path_on = (mode == `GPC_MODE_OUTPUT) || (mode == `GPC_MODE_BIDIR);
  wire clk_path_on = (mode == `GPC_MODE_CLKOUT);
  wire active      = user_mode & used;

  // ************************************************************
  // input synchronisers for off-domain levels
  // ************************************************************
  gpc_edge_sync u_cap_sync
  (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .async_in  (capture_clock_in),
    .level_out (cap_lvl),
    .rise_out  (cap_rise),
    .fall_out  (cap_fall)
  );

  gpc_edge_sync u_lch_sync
  (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .async_in  (launch_clock_in),
    .level_out (lch_lvl),
    .rise_out  (lch_rise),
    .fall_out  (lch_fall)
  );

  gpc_edge_sync u_pad_sync
  (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .async_in  (pad_in),
    .level_out (pad_lvl),
    .rise_out  (),
    .fall_out  ()
  );

  gpc_edge_sync u_tree_sync
  (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .async_in  (clock_tree_in),
    .level_out (tree_lvl),
    .rise_out  (),
    .fall_out  ()
  );

  // ************************************************************
  // edge selection per register
  // ************************************************************
  wire in_edge  = in_fall ? cap_fall : cap_rise;
  wire out_edge = out_fall ? lch_fall : lch_rise;
  wire oe_edge  = oe_fall ? lch_fall : lch_rise;

  // ************************************************************
  // register port
  // ************************************************************
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ctrl_q  <= `GPC_CTRL_RESET;
      route_q <= `GPC_ROUTE_RESET;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        `GPC_OFF_CTRL:  ctrl_q  <= reg_wdata_in[`GPC_CTRL_W-1:0];
        `GPC_OFF_ROUTE: route_q <= reg_wdata_in[`GPC_ROUTE_W-1:0];
        default:        ctrl_q  <= ctrl_q;
      endcase
    end
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        `GPC_OFF_CTRL:   reg_rdata_out <= {17'h0_0000, ctrl_q};
        `GPC_OFF_ROUTE:  reg_rdata_out <= {30'h0000_0000, route_q};
        `GPC_OFF_STATUS: reg_rdata_out <= {24'h00_0000, user_mode, ~pad_oe_n_out, pad_out,
                                           pad_lvl, core_in_out, lch_lvl, cap_lvl};
        default:         reg_rdata_out <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata_out <= 32'h0000_0000;
  end

  // ************************************************************
  // configuration and user phases
  // ************************************************************
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_CONFIG: if (ctrl_q[`GPC_CTRL_CFG_DONE]) state_d = ST_USER;
      ST_USER:   if (!ctrl_q[`GPC_CTRL_CFG_DONE]) state_d = ST_CONFIG;
      default:   state_d = ST_CONFIG;
    endcase
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
      state_q <= ST_CONFIG;
    else
      state_q <= state_d;
  end

  // ************************************************************
  // input path
  // ************************************************************
  reg in_rise_q;
  reg in_fall_q;
  reg in_sgl_q;

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      in_rise_q <= 1'h0;
      in_fall_q <= 1'h0;
      in_sgl_q  <= 1'h0;
    end
    else
    begin
      if (cap_rise)
        in_rise_q <= pad_lvl;
      if (cap_fall)
        in_fall_q <= pad_lvl;
      if (in_edge)
        in_sgl_q <= pad_lvl;
    end
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
      core_in_out <= 2'h0;
    else if (!(active && in_path_on))
      core_in_out <= 2'h0;
    else if (dual_in)
      core_in_out <= {in_fall_q, in_rise_q};
    else if (in_reg)
      core_in_out <= {1'h0, in_sgl_q};
    else
      core_in_out <= {1'h0, pad_lvl};
  end

  // ************************************************************
  // bypass routing, no capture register on this path
  // ************************************************************
  // only the synchroniser stands in front; no option adds a register here
  wire byp_ok = active && in_path_on && !in_reg && !dual_in;

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      global_clock_net_out    <= 1'h0;
      global_control_net_out  <= 1'h0;
      pll_reference_input_out <= 1'h0;
    end
    else
    begin
      global_clock_net_out    <= byp_ok && (route_q == `GPC_ROUTE_GLOBAL_CLOCK_NET) && pad_lvl;
      global_control_net_out  <= byp_ok && (route_q == `GPC_ROUTE_GLOBAL_CONTROL_NET) && pad_lvl;
      pll_reference_input_out <= byp_ok && (route_q == `GPC_ROUTE_PLL) && pad_lvl;
    end
  end

  // ************************************************************
  // output and drive-enable registers
  // ************************************************************
  reg out_sgl_q;
  reg out_hi_q;
  reg out_lo_q;
  reg oe_q;

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      out_sgl_q <= 1'h0;
      out_hi_q  <= 1'h0;
      out_lo_q  <= 1'h0;
      oe_q      <= 1'h0;
    end
    else
    begin
      if (out_edge)
        out_sgl_q <= core_out_in[0];
      if (lch_rise)
        out_hi_q <= core_out_in[0];
      if (lch_fall)
        out_lo_q <= core_out_in[1];
      if (oe_edge)
        oe_q <= core_oe_in;
    end
  end

  // ************************************************************
  // effective output value and drive enable
  // ************************************************************
  reg out_val;
  reg drive;

  always @*
  begin
    out_val = 1'h0;
    drive   = 1'h0;
    if (active)
    begin
      if (clk_path_on)
      begin
        out_val = tree_lvl;
        drive   = 1'h1;
      end
      else if (out_path_on)
      begin
        if (dual_out)
          out_val = (lch_lvl ? out_hi_q : out_lo_q) ^ out_inv;
        else if (out_reg)
          out_val = out_sgl_q ^ out_inv;
        else
          out_val = core_out_in[0];
        if (mode == `GPC_MODE_BIDIR)
          drive = oe_reg ? oe_q : core_oe_in;
        else
          drive = 1'h1;
      end
    end
  end

  // ************************************************************
  // pad buffer and pulls
  // ************************************************************
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pad_out           <= 1'h0;
      pad_oe_n_out      <= 1'h1;
      pad_pull_up_out   <= 1'h1;
      pad_pull_down_out <= 1'h0;
    end
    else
    begin
      pad_out      <= drive & out_val;
      pad_oe_n_out <= ~drive;
      if (!user_mode)
      begin
        pad_pull_up_out   <= ~diff_pin;
        pad_pull_down_out <= 1'h0;
      end
      else if (!used)
      begin
        // differential pins have no pull-down, keep the pull-up there
        pad_pull_up_out   <= ~pull_down | diff_pin;
        pad_pull_down_out <= pull_down & ~diff_pin;
      end
      else
      begin
        pad_pull_up_out   <= 1'h0;
        pad_pull_down_out <= 1'h0;
      end
    end
  end

endmodule // gpc_io_cell

// ==== hdl/gpc_regs.vh ====
`ifndef GPC_REGS_VH
`define GPC_REGS_VH

// ************************************************************
// register offsets
// ************************************************************
`define GPC_ADDR_W          4
`define GPC_OFF_CTRL        4'h0
`define GPC_OFF_ROUTE       4'h4
`define GPC_OFF_STATUS      4'h8

// ************************************************************
// control register fields
// ************************************************************
`define GPC_CTRL_MODE_LSB   0
`define GPC_CTRL_MODE_MSB   1
`define GPC_CTRL_IN_REG     2
`define GPC_CTRL_IN_FALL    3
`define GPC_CTRL_OUT_REG    4
`define GPC_CTRL_OUT_FALL   5
`define GPC_CTRL_OUT_INV    6
`define GPC_CTRL_OE_REG     7
`define GPC_CTRL_OE_FALL    8
`define GPC_CTRL_DUAL_IN    9
`define GPC_CTRL_DUAL_OUT   10
`define GPC_CTRL_PULL_DOWN  11
`define GPC_CTRL_DIFF_PIN   12
`define GPC_CTRL_CFG_DONE   13
`define GPC_CTRL_USED       14
`define GPC_CTRL_W          15
`define GPC_CTRL_RESET      15'h0000

// ************************************************************
// bypass routing field
// ************************************************************
`define GPC_ROUTE_W         2
`define GPC_ROUTE_RESET     2'h0
`define GPC_ROUTE_NONE      2'h0
`define GPC_ROUTE_GLOBAL_CLOCK_NET      2'h1
`define GPC_ROUTE_GLOBAL_CONTROL_NET     2'h2
`define GPC_ROUTE_PLL       2'h3

// ************************************************************
// cell modes
// ************************************************************
`define GPC_MODE_INPUT      2'h0
`define GPC_MODE_OUTPUT     2'h1
`define GPC_MODE_BIDIR      2'h2
`define GPC_MODE_CLKOUT     2'h3

`endif

// ==== tb/gpc_io_cell_chk.sv ====
`timescale 1ns/1ps
`include "gpc_regs.vh"

module gpc_io_cell_chk
(
  // clock and reset
  input wire                   clk_in,
  input wire                   rst_in,
  // register port
  input wire [`GPC_ADDR_W-1:0] reg_addr_in,
  input wire                   reg_rd_in,
  input wire [31:0]            reg_rdata_out,
  // bypass routing
  input wire                   global_clock_net_out,
  input wire                   global_control_net_out,
  input wire                   pll_reference_input_out,
  // pad
  input wire                   pad_out,
  input wire                   pad_oe_n_out,
  input wire                   pad_pull_up_out,
  input wire                   pad_pull_down_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // ************************************************************
  // register reads
  // ************************************************************
  sequence s_rd(a);
    reg_rd_in && reg_addr_in == a;
  endsequence
  property p_unmapped_rd;
    s_rd(4'hC) |=> reg_rdata_out == 32'h0;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
  property p_route_rd;
    s_rd(`GPC_OFF_ROUTE) |=> reg_rdata_out[31:2] == 30'h0;
  endproperty
  a_route_rd: assert property (p_route_rd) else $error("route upper bits set");
  property p_rd_stands;
    !reg_rd_in |=> reg_rdata_out == 32'h0;
  endproperty
  a_rd_stands: assert property (p_rd_stands) else $error("read data outside its cycle");

  // ************************************************************
  // pad and routing
  // ************************************************************
  property p_hiz;
    pad_oe_n_out |-> pad_out == 1'b0;
  endproperty
  a_hiz: assert property (p_hiz) else $error("pad value while undriven");
  property p_pull_excl;
    !(pad_pull_up_out && pad_pull_down_out);
  endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");
  property p_drive_nopull;
    !pad_oe_n_out |-> !pad_pull_up_out && !pad_pull_down_out;
  endproperty
  a_drive_nopull: assert property (p_drive_nopull) else $error("pull on driven pad");
  property p_bypass_one;
    $onehot0({global_clock_net_out, global_control_net_out, pll_reference_input_out});
  endproperty
  a_bypass_one: assert property (p_bypass_one) else $error("bypass on two nets");
  property p_rst_cfg;
    $fell(rst_in) |-> pad_oe_n_out && pad_pull_up_out && !pad_pull_down_out;
  endproperty
  a_rst_cfg: assert property (p_rst_cfg) else $error("pad not pulled up in configuration");
endmodule // gpc_io_cell_chk

bind gpc_io_cell gpc_io_cell_chk u_gpc_io_cell_chk (.*);

// ==== tb/gpc_pad_model.sv ====
`timescale 1ns/1ps

module gpc_pad_model
(
  // clock
  input  wire clk_in,
  // cell side
  input  wire drive_in,
  input  wire drive_oe_n_in,
  input  wire pull_up_in,
  input  wire pull_down_in,
  // external driver
  input  wire ext_en_in,
  input  wire ext_val_in,
  // resolved pad
  output reg  level_out
);
  initial level_out = 1'b0;
  always @(posedge clk_in)
  begin
    if (!drive_oe_n_in)
      level_out <= drive_in;
    else if (ext_en_in)
      level_out <= ext_val_in;
    else if (pull_up_in)
      level_out <= 1'b1;
    else if (pull_down_in)
      level_out <= 1'b0;
    else
      level_out <= ~level_out;
  end
endmodule // gpc_pad_model

// ==== tb/test_gpc_io_cell.sv ====
`timescale 1ns/1ps
`include "gpc_regs.vh"

module test_gpc_io_cell;
  reg         clk_in = 1'b0;
  reg         rst_in = 1'b1;
  reg  [3:0]  reg_addr_in = 4'h0;
  reg  [31:0] reg_wdata_in = 32'h0;
  reg         reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  reg         cap = 1'b0, launch = 1'b0, tree = 1'b0, core_oe = 1'b0;
  reg  [1:0]  core_out = 2'h0;
  reg         ext_en = 1'b0, ext_val = 1'b0;
  wire [31:0] reg_rdata_out;
  wire [1:0]  core_in;
  wire        global_clock_net, gctl, pllr, pad_lvl, pad_o, oe_n, pu, pd;
  integer     fails = 0, comparisons = 0, cyc = 0, i;

  gpc_io_cell u_gpc_io_cell (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .capture_clock_in(cap), .launch_clock_in(launch),
    .clock_tree_in(tree), .core_out_in(core_out), .core_oe_in(core_oe), .core_in_out(core_in),
    .global_clock_net_out(global_clock_net), .global_control_net_out(gctl), .pll_reference_input_out(pllr),
    .pad_in(pad_lvl), .pad_out(pad_o), .pad_oe_n_out(oe_n), .pad_pull_up_out(pu),
    .pad_pull_down_out(pd));
  gpc_pad_model u_gpc_pad_model (.clk_in(clk_in), .drive_in(pad_o), .drive_oe_n_in(oe_n),
    .pull_up_in(pu), .pull_down_in(pd), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .level_out(pad_lvl));

  initial forever #5 clk_in = ~clk_in;

  // ************************************************************
  // shared tasks
  // ************************************************************
  task results;
  begin
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  // hang guard: whole run needs well under 2000 cycles
  always @(posedge clk_in)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      results;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task tick(input integer n);
  begin
    repeat (n) @(posedge clk_in);
    #1;
  end
  endtask
  task wr(input [3:0] a, input [31:0] d);
  begin
    @(posedge clk_in) reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in) reg_wr_in <= 1'b0;
  end
  endtask
  task rd(input [3:0] a, input [31:0] e);
  begin
    @(posedge clk_in) reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in) reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, e);
  end
  endtask
  // async pad and clocks need several cycles to settle
  task cfg(input [31:0] d);
  begin
    wr(`GPC_OFF_CTRL, d);
    tick(8);
  end
  endtask
  // pad data settles through model and synchroniser before each capture edge
  task cap_seq;
  begin
    @(posedge clk_in) ext_val <= 1'b1;
    tick(8);
    @(posedge clk_in) cap <= 1'b1;
    tick(8);
    @(posedge clk_in) ext_val <= 1'b0;
    tick(8);
    @(posedge clk_in) cap <= 1'b0;
    tick(8);
  end
  endtask
  task done(input [63:0] name);
    $display("test %0s done", name);
  endtask

  // ************************************************************
  // tests
  // ************************************************************
  initial
  begin
    tick(15);
    @(posedge clk_in) rst_in <= 1'b0;
    tick(2);
    chk(pu, 1'b1);
    chk(pd, 1'b0);
    chk(oe_n, 1'b1);
    rd(`GPC_OFF_CTRL, `GPC_CTRL_RESET);
    rd(`GPC_OFF_ROUTE, `GPC_ROUTE_RESET);
    wr(4'hC, 32'hFFFFFFFF);
    rd(4'hC, 32'h0);
    done("reset");
    cfg(32'h1000);
    chk({pu, pd, oe_n}, 3'h1);
    cfg(32'h2000);
    chk({pu, pd, oe_n}, 3'h5);
    cfg(32'h2800);
    chk({pu, pd, oe_n}, 3'h3);
    done("pulls");
    cfg(32'h6001);
    @(posedge clk_in) core_out <= 2'h1;
    tick(8);
    chk({pad_o, oe_n, core_in}, 4'h8);
    @(posedge clk_in) core_out <= 2'h0;
    tick(2);
    chk(pad_o, 1'b0);
    for (i = 0; i < 2; i = i + 1)
    begin
      cfg(32'h6051 | (i << 5));
      @(posedge clk_in) core_out <= 2'h1;
      launch <= 1'b1;
      tick(8);
      @(posedge clk_in) core_out <= 2'h0;
      launch <= 1'b0;
      tick(8);
      chk(pad_o, i);
    end
    cfg(32'h6411);
    for (i = 1; i < 3; i = i + 1)
    begin
      @(posedge clk_in) core_out <= i;
      launch <= 1'b1;
      tick(8);
      chk(pad_o, i & 1);
      @(posedge clk_in) launch <= 1'b0;
      tick(8);
      chk(pad_o, i >> 1);
    end
    done("output");
    cfg(32'h6000);
    @(posedge clk_in) ext_en <= 1'b1;
    ext_val <= 1'b1;
    tick(8);
    chk({core_in, oe_n}, 3'h3);
    for (i = 1; i < 4; i = i + 1)
    begin
      wr(`GPC_OFF_ROUTE, i);
      tick(4);
      chk({pllr, gctl, global_clock_net}, 1 << (i - 1));
    end
    for (i = 0; i < 2; i = i + 1)
    begin
      cfg(32'h6004 | (i << 3));
      chk({pllr, gctl, global_clock_net}, 3'h0);
      cap_seq;
      chk(core_in, 1 - i);
    end
    cfg(32'h6204);
    cap_seq;
    chk(core_in, 2'h1);
    done("input");
    cfg(32'h6002);
    @(posedge clk_in) ext_val <= 1'b1;
    tick(8);
    chk({oe_n, pad_o, core_in}, 4'h9);
    @(posedge clk_in) ext_en <= 1'b0;
    core_oe <= 1'b1;
    core_out <= 2'h1;
    tick(8);
    chk({oe_n, pad_o, core_in}, 4'h5);
    cfg(32'h6003);
    @(posedge clk_in) tree <= 1'b1;
    tick(8);
    chk({oe_n, pad_o}, 2'h1);
    @(posedge clk_in) tree <= 1'b0;
    tick(8);
    chk(pad_o, 1'b0);
    cfg(32'h6082);
    chk(oe_n, 1'b1);
    @(posedge clk_in) launch <= 1'b1;
    tick(8);
    chk({oe_n, pad_o}, 2'h1);
    cfg(32'h6182);
    @(posedge clk_in) launch <= 1'b0;
    core_oe <= 1'b0;
    tick(8);
    chk(oe_n, 1'b1);
    done("bidir");
    results;
  end
endmodule // test_gpc_io_cell
